// *** shared/homing_regs.svh ***
/*
 Offsets, reset values and codes of the homing sequencer.
 Assumes the object port carries a 16-bit index and an 8-bit sub-index.
*/
// Functional notes
// - Methods 24 and 28 search the home sensor, positive and negative.
// - On home, reverse out at start speed, reverse again at zero speed.
// - Home searches stop on home sensor rising edge; stop is home.
// - Methods 17 and 18 search limits, negative and positive start.
// - Two-sensor: after leaving limit, move backward steps, stop, set home.
// - Vendor mode 1 with no sensor_input_a or zero equals methods 24/28.
// - Vendor mode 0 with no sensor_input_a or zero equals methods 17/18.
// - Direction field: 1 starts positive, 0 starts negative.
// - Methods 35/37 preset home in place unless operation enabled.
// - Three-sensor runs at switch speed, reverses off limits, stops on home.
// - Three-sensor with external signal ends on it while home is on.
// - Two-sensor runs at start speed, reverses off the limit first.
// - Two-sensor and one-way with external signal end on that signal.
// - One-way runs at switch speed, stops on home, leaves at zero speed.
// - One-way moves the operating amount after leaving home, sets home.
// - Leaving home during one-way deceleration raises alarm 62h.
// - Method -1 selects the vendor mode objects.
`ifndef HOMING_REGS_SVH
`define HOMING_REGS_SVH

`define IDX_METHOD      16'h6098
`define IDX_SPEEDS      16'h6099
`define SUB_SW_SPEED    8'h01
`define SUB_ZERO_SPEED  8'h02
`define IDX_ACCEL       16'h609A
`define IDX_MODE        16'h4160
`define IDX_START_DIR   16'h4161
`define IDX_START_SPEED 16'h4163
`define IDX_SENSOR_INPUT_A_EN     16'h4166
`define IDX_ZERO_EN     16'h4167
`define IDX_BACK_STEPS  16'h4169
`define IDX_ONE_WAY     16'h416A

`define RST_METHOD      8'h18
`define RST_SW_SPEED    32'h0000_2710
`define RST_ZERO_SPEED  32'h0000_1388
`define RST_ACCEL       32'h0004_93E0
`define RST_MODE        8'h00
`define RST_START_DIR   8'h01
`define RST_START_SPEED 32'h0000_1388
`define RST_BACK_STEPS  32'h0000_1388
`define RST_ONE_WAY     32'h0000_1388

`define METH_LIM_NEG    8'h11
`define METH_LIM_POS    8'h12
`define METH_HOME_POS   8'h18
`define METH_HOME_NEG   8'h1C
`define METH_PRESET_A   8'h23
`define METH_PRESET_B   8'h25
`define METH_VENDOR     8'hFF

`define MODE_TWO        8'h00
`define MODE_THREE      8'h01
`define MODE_ONE_WAY    8'h02
`define ZERO_EN_CODE    8'h02
`define ALARM_HOME_ERR  8'h62

`endif

// *** shared/homing_pkg.sv ***
/*
 Types of the homing sequencer.
 Assumes nothing beyond the constants header.
*/
package homing_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_SEEK  = 4'h1,
        ST_ESC   = 4'h3,
        ST_DECEL = 4'h2,
        ST_LEAVE = 4'h6,
        ST_ZERO  = 4'h7,
        ST_STEP  = 4'h5,
        ST_EXT   = 4'h4,
        ST_STOP  = 4'hC,
        ST_ERR   = 4'hD
    } home_state_t;

    typedef enum logic [1:0] {
        SEQ_TWO, SEQ_THREE, SEQ_ONE_WAY
    } home_seq_t;

    typedef struct packed {
        logic        run;
        logic        dir;
        logic [31:0] speed;
        logic [31:0] accel;
    } motion_cmd_t;

    typedef struct packed {
        logic       busy;
        logic       done;
        logic       error;
        logic [7:0] alarm_code;
    } home_status_t;
endpackage : homing_pkg

// *** logic/homing_sequencer.sv ***
/*
 Homing sequencer: object registers, method decode and motion sequence.
 Assumes synchronous sensors and a stage that obeys motion_cmd.
*/
`timescale 1ns/1ns
`include "homing_regs.svh"
module homing_sequencer (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // Object access from the fieldbus side
    input  wire logic                  obj_wr,
    input  wire logic                  obj_rd,
    input  wire logic [15:0]           obj_index,
    input  wire logic [7:0]            obj_sub,
    input  wire logic [31:0]           obj_wdata,
    output      logic [31:0]           obj_rdata,
    output      logic                  obj_err,
    // Drive control
    input  wire logic                  home_start,
    input  wire logic                  op_enabled,
    // Sensors
    input  wire logic                  home_sensor_input,
    input  wire logic                  forward_limit_input,
    input  wire logic                  reverse_limit_input,
    input  wire logic                  sensor_input_a,
    input  wire logic                  encoder_zero_signal,
    // Motion stage
    input  wire logic                  motion_stopped,
    input  wire logic                  step_tick,
    output homing_pkg::motion_cmd_t    motion_cmd,
    output logic                       home_set,
    output homing_pkg::home_status_t   status
);
    import homing_pkg::*;

    // Object registers
    logic [7:0]  method_r, method_nxt, mode_r, mode_nxt;
    logic [7:0]  start_dir_r, start_dir_nxt, sensor_input_a_en_r, sensor_input_a_en_nxt;
    logic [7:0]  zero_en_r, zero_en_nxt;
    logic [31:0] sw_speed_r, sw_speed_nxt, zero_speed_r, zero_speed_nxt;
    logic [31:0] accel_r, accel_nxt, start_speed_r, start_speed_nxt;
    logic [31:0] back_steps_r, back_steps_nxt, one_way_r, one_way_nxt;
    logic [31:0] rdata_nxt;
    logic        err_nxt;

    // Register writes and reads
    always_comb begin
        method_nxt      = method_r;
        sw_speed_nxt    = sw_speed_r;
        zero_speed_nxt  = zero_speed_r;
        accel_nxt       = accel_r;
        mode_nxt        = mode_r;
        start_dir_nxt   = start_dir_r;
        start_speed_nxt = start_speed_r;
        sensor_input_a_en_nxt     = sensor_input_a_en_r;
        zero_en_nxt     = zero_en_r;
        back_steps_nxt  = back_steps_r;
        one_way_nxt     = one_way_r;
        rdata_nxt       = 32'h0000_0000;
        err_nxt         = 1'b0;
        unique case (obj_index)
            `IDX_METHOD: begin
                if (obj_wr) method_nxt = obj_wdata[7:0];
                rdata_nxt = {{24{method_r[7]}}, method_r};
            end
            `IDX_SPEEDS: begin
                if (obj_sub == `SUB_SW_SPEED) begin
                    if (obj_wr) sw_speed_nxt = obj_wdata;
                    rdata_nxt = sw_speed_r;
                end else if (obj_sub == `SUB_ZERO_SPEED) begin
                    if (obj_wr) zero_speed_nxt = obj_wdata;
                    rdata_nxt = zero_speed_r;
                end else begin
                    err_nxt = obj_wr | obj_rd;
                end
            end
            `IDX_ACCEL: begin
                if (obj_wr) accel_nxt = obj_wdata;
                rdata_nxt = accel_r;
            end
            `IDX_MODE: begin
                if (obj_wr) mode_nxt = obj_wdata[7:0];
                rdata_nxt = {24'h000000, mode_r};
            end
            `IDX_START_DIR: begin
                if (obj_wr) start_dir_nxt = obj_wdata[7:0];
                rdata_nxt = {24'h000000, start_dir_r};
            end
            `IDX_START_SPEED: begin
                if (obj_wr) start_speed_nxt = obj_wdata;
                rdata_nxt = start_speed_r;
            end
            `IDX_SENSOR_INPUT_A_EN: begin
                if (obj_wr) sensor_input_a_en_nxt = obj_wdata[7:0];
                rdata_nxt = {24'h000000, sensor_input_a_en_r};
            end
            `IDX_ZERO_EN: begin
                if (obj_wr) zero_en_nxt = obj_wdata[7:0];
                rdata_nxt = {24'h000000, zero_en_r};
            end
            `IDX_BACK_STEPS: begin
                if (obj_wr) back_steps_nxt = obj_wdata;
                rdata_nxt = back_steps_r;
            end
            `IDX_ONE_WAY: begin
                if (obj_wr) one_way_nxt = obj_wdata;
                rdata_nxt = one_way_r;
            end
            default: err_nxt = obj_wr | obj_rd;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            method_r      <= `RST_METHOD;
            sw_speed_r    <= `RST_SW_SPEED;
            zero_speed_r  <= `RST_ZERO_SPEED;
            accel_r       <= `RST_ACCEL;
            mode_r        <= `RST_MODE;
            start_dir_r   <= `RST_START_DIR;
            start_speed_r <= `RST_START_SPEED;
            sensor_input_a_en_r     <= 8'h00;
            zero_en_r     <= 8'h00;
            back_steps_r  <= `RST_BACK_STEPS;
            one_way_r     <= `RST_ONE_WAY;
            obj_rdata     <= 32'h0000_0000;
            obj_err       <= 1'b0;
        end else begin
            method_r      <= method_nxt;
            sw_speed_r    <= sw_speed_nxt;
            zero_speed_r  <= zero_speed_nxt;
            accel_r       <= accel_nxt;
            mode_r        <= mode_nxt;
            start_dir_r   <= start_dir_nxt;
            start_speed_r <= start_speed_nxt;
            sensor_input_a_en_r     <= sensor_input_a_en_nxt;
            zero_en_r     <= zero_en_nxt;
            back_steps_r  <= back_steps_nxt;
            one_way_r     <= one_way_nxt;
            obj_rdata     <= rdata_nxt;
            obj_err       <= err_nxt;
        end
    end

    // Method decode; the profile methods force the external signals off
    logic      dec_ok, dec_dir, dec_preset, dec_ext;
    home_seq_t dec_seq;
    always_comb begin
        dec_ok     = 1'b1;
        dec_dir    = 1'b1;
        dec_preset = 1'b0;
        dec_ext    = 1'b0;
        dec_seq    = SEQ_THREE;
        unique case (method_r)
            `METH_HOME_POS: dec_dir = 1'b1;
            `METH_HOME_NEG: dec_dir = 1'b0;
            `METH_LIM_NEG: begin
                dec_seq = SEQ_TWO;
                dec_dir = 1'b0;
            end
            `METH_LIM_POS: dec_seq = SEQ_TWO;
            `METH_PRESET_A, `METH_PRESET_B: dec_preset = 1'b1;
            `METH_VENDOR: begin
                dec_dir = (start_dir_r == 8'h01);
                dec_ext = (sensor_input_a_en_r != 8'h00) ||
                          (zero_en_r == `ZERO_EN_CODE);
                if (mode_r == `MODE_TWO) dec_seq = SEQ_TWO;
                else if (mode_r == `MODE_THREE) dec_seq = SEQ_THREE;
                else if (mode_r == `MODE_ONE_WAY) dec_seq = SEQ_ONE_WAY;
                else dec_ok = 1'b0;
            end
            default: dec_ok = 1'b0;
        endcase
    end

    // Sequencer state
    home_state_t  state_r, state_nxt;
    home_seq_t    seq_r, seq_nxt;
    logic         dir_r, dir_nxt, ext_r, ext_nxt, home_prev_r, home_set_nxt;
    logic [31:0]  steps_r, steps_nxt;
    motion_cmd_t  cmd_nxt;
    home_status_t status_nxt;

    logic home_rise, lim_ahead, lim_any, ext_hit, sensor_input_a_use, zero_use;
    assign home_rise = home_sensor_input & ~home_prev_r;
    assign lim_ahead = dir_r ? forward_limit_input : reverse_limit_input;
    assign lim_any   = forward_limit_input | reverse_limit_input;
    assign sensor_input_a_use  = sensor_input_a_en_r != 8'h00;
    assign zero_use  = zero_en_r == `ZERO_EN_CODE;
    assign ext_hit   = (sensor_input_a_use & sensor_input_a) |
                       (zero_use & encoder_zero_signal);

    // Next state and motion command
    always_comb begin
        state_nxt    = state_r;
        seq_nxt      = seq_r;
        dir_nxt      = dir_r;
        ext_nxt      = ext_r;
        steps_nxt    = steps_r;
        home_set_nxt = 1'b0;
        status_nxt   = status;
        cmd_nxt      = motion_cmd;
        cmd_nxt.run  = 1'b1;
        cmd_nxt.accel = accel_r;
        unique case (state_r)
            ST_IDLE: begin
                cmd_nxt.run = 1'b0;
                if (home_start && dec_ok && dec_preset && !op_enabled) begin
                    home_set_nxt    = 1'b1;
                    status_nxt.done = 1'b1;
                    status_nxt.error = 1'b0;
                end else if (home_start && dec_ok && !dec_preset &&
                             op_enabled) begin
                    seq_nxt   = dec_seq;
                    dir_nxt   = dec_dir;
                    ext_nxt   = dec_ext;
                    state_nxt = ST_SEEK;
                    cmd_nxt.run   = 1'b1;
                    cmd_nxt.dir   = dec_dir;
                    cmd_nxt.speed = dec_seq == SEQ_TWO ? start_speed_r
                                  : sw_speed_r;
                    status_nxt = '{busy: 1'b1, done: 1'b0, error: 1'b0,
                                   alarm_code: 8'h00};
                end
            end
            ST_SEEK: begin
                if (seq_r != SEQ_ONE_WAY && lim_ahead) begin
                    dir_nxt   = ~dir_r;
                    state_nxt = ST_ESC;
                end else if (seq_r == SEQ_THREE && home_rise) begin
                    dir_nxt   = ~dir_r;
                    state_nxt = ST_LEAVE;
                end else if (seq_r == SEQ_ONE_WAY && home_rise) begin
                    state_nxt = ST_DECEL;
                end
            end
            ST_ESC: begin
                cmd_nxt.dir = dir_r;
                if (!lim_any && seq_r == SEQ_TWO) begin
                    steps_nxt = back_steps_r;
                    state_nxt = ST_STEP;
                end else if (!lim_any) begin
                    state_nxt = ST_SEEK;
                end
            end
            ST_DECEL: begin
                cmd_nxt.run = 1'b0;
                if (!home_sensor_input) begin
                    state_nxt = ST_ERR;
                    status_nxt.alarm_code = `ALARM_HOME_ERR;
                    status_nxt.error = 1'b1;
                    status_nxt.busy  = 1'b0;
                end else if (motion_stopped) begin
                    state_nxt = ST_LEAVE;
                end
            end
            ST_LEAVE: begin
                cmd_nxt.dir   = dir_r;
                cmd_nxt.speed = (seq_r == SEQ_ONE_WAY) ? zero_speed_r
                                                       : start_speed_r;
                if (!home_sensor_input && seq_r == SEQ_ONE_WAY) begin
                    steps_nxt = one_way_r;
                    state_nxt = ST_STEP;
                end else if (!home_sensor_input) begin
                    dir_nxt   = ~dir_r;
                    state_nxt = ST_ZERO;
                end
            end
            ST_ZERO: begin
                cmd_nxt.dir   = dir_r;
                cmd_nxt.speed = zero_speed_r;
                if (home_rise) begin
                    state_nxt = ext_r ? ST_EXT : ST_STOP;
                    cmd_nxt.run = ext_r;
                end
            end
            ST_STEP: begin
                if (steps_r == 32'h0000_0000) begin
                    state_nxt = ext_r ? ST_EXT : ST_STOP;
                    cmd_nxt.run = ext_r;
                end else if (step_tick) begin
                    steps_nxt = steps_r - 32'h0000_0001;
                end
            end
            ST_EXT: begin
                // Three-sensor accepts the signal only inside the home zone
                if (ext_hit && (seq_r != SEQ_THREE ||
                                home_sensor_input)) begin
                    state_nxt = ST_STOP;
                    cmd_nxt.run = 1'b0;
                end
            end
            ST_STOP: begin
                cmd_nxt.run = 1'b0;
                if (motion_stopped) begin
                    home_set_nxt    = 1'b1;
                    status_nxt.busy = 1'b0;
                    status_nxt.done = 1'b1;
                    state_nxt       = ST_IDLE;
                end
            end
            ST_ERR: begin
                // Held until a new start so the alarm is not missed
                cmd_nxt.run = 1'b0;
                if (home_start) state_nxt = ST_IDLE;
            end
            default: begin
                cmd_nxt.run = 1'b0;
                state_nxt   = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            seq_r       <= SEQ_THREE;
            dir_r       <= 1'b1;
            ext_r       <= 1'b0;
            steps_r     <= 32'h0000_0000;
            home_prev_r <= 1'b0;
            motion_cmd  <= '0;
            home_set    <= 1'b0;
            status      <= '0;
        end else begin
            state_r     <= state_nxt;
            seq_r       <= seq_nxt;
            dir_r       <= dir_nxt;
            ext_r       <= ext_nxt;
            steps_r     <= steps_nxt;
            home_prev_r <= home_sensor_input;
            motion_cmd  <= cmd_nxt;
            home_set    <= home_set_nxt;
            status      <= status_nxt;
        end
    end
endmodule : homing_sequencer

// *** tb/homing_sequencer_assertions.sv ***
/*
 Checker of the homing sequencer, bound to its ports.
 Assumes the method object is only changed through obj_wr.
*/
`timescale 1ns/1ns
`include "homing_regs.svh"
module homing_sequencer_assertions (
    // Clock and reset
    input wire logic                clock,
    input wire logic                rst,
    // Object writes and drive control
    input wire logic                obj_wr,
    input wire logic [15:0]         obj_index,
    input wire logic [31:0]         obj_wdata,
    input wire logic                home_start,
    input wire logic                op_enabled,
    // Results
    input wire logic                motion_stopped,
    input homing_pkg::motion_cmd_t  motion_cmd,
    input wire logic                home_set,
    input homing_pkg::home_status_t status
);
    import homing_pkg::*;
    logic [7:0] meth_r;
    logic       go;
    logic       pre;
    // Shadow of the method object, so start decode can be judged
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            meth_r <= `RST_METHOD;
        else if (obj_wr && obj_index == `IDX_METHOD)
            meth_r <= obj_wdata[7:0];
    end
    // Only a start in idle without a standing error is taken
    assign go = home_start && !status.busy && !status.error;
    assign pre = meth_r == `METH_PRESET_A || meth_r == `METH_PRESET_B;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_preset;
        go && !op_enabled && pre |=> home_set && status.done;
    endproperty
    a_preset: assert property (p_preset)
        else $error("preset did not set home");
    property p_preset_block;
        go && op_enabled && pre |=> (!home_set && !status.busy) [*3];
    endproperty
    a_preset_block: assert property (p_preset_block)
        else $error("preset ran while operation enabled");
    property p_start_pos;
        go && op_enabled && (meth_r == `METH_HOME_POS ||
            meth_r == `METH_LIM_POS) |=> motion_cmd.run && motion_cmd.dir;
    endproperty
    a_start_pos: assert property (p_start_pos)
        else $error("positive method did not start positive");
    property p_start_neg;
        go && op_enabled && (meth_r == `METH_HOME_NEG ||
            meth_r == `METH_LIM_NEG) |=> motion_cmd.run && !motion_cmd.dir;
    endproperty
    a_start_neg: assert property (p_start_neg)
        else $error("negative method did not start negative");
    property p_set_done;
        home_set |-> status.done && !status.busy && !motion_cmd.run;
    endproperty
    a_set_done: assert property (p_set_done)
        else $error("home set without completion");
    property p_set_pulse;
        home_set |=> !home_set;
    endproperty
    a_set_pulse: assert property (p_set_pulse)
        else $error("home set longer than one cycle");
    property p_done_stop;
        $rose(status.done) && $past(status.busy)
            |-> !motion_cmd.run && $past(motion_stopped) && home_set;
    endproperty
    a_done_stop: assert property (p_done_stop)
        else $error("completion before the motor stopped");
    property p_alarm;
        $rose(status.error) |-> status.alarm_code == `ALARM_HOME_ERR
            && !status.busy && !motion_cmd.run && !home_set;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("homing error without its alarm code");
    property p_run_busy;
        motion_cmd.run |-> status.busy;
    endproperty
    a_run_busy: assert property (p_run_busy)
        else $error("motor commanded outside a sequence");
endmodule : homing_sequencer_assertions

bind homing_sequencer homing_sequencer_assertions chk (.*);

// *** tb/motion_stage_model.sv ***
/*
 Motor, stage and sensor model beside the homing sequencer.
 Assumes the bench loads start positions while the motor is at rest.
*/
`timescale 1ns/1ns
module motion_stage_model #(
    parameter int HOME_LO = 20,
    parameter int HOME_HI = 29,
    parameter int LIMIT   = 60
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // Bench control
    input  wire logic               load,
    input  wire logic signed [31:0] load_pos,
    input  wire logic [3:0]         coast,
    // Command from the sequencer
    input  homing_pkg::motion_cmd_t motion_cmd,
    // Stage and sensors
    output logic                    motion_stopped,
    output logic                    step_tick,
    output logic signed [31:0]      pos,
    output logic                    home_sensor_input,
    output logic                    forward_limit_input,
    output logic                    reverse_limit_input
);
    logic [1:0] ph_r;
    logic [3:0] left_r;
    logic       dir_r;
    // One step every fourth cycle leaves the sequencer time to react
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pos <= '0;
            ph_r <= 2'h0;
            left_r <= 4'h0;
            dir_r <= 1'b1;
            step_tick <= 1'b0;
        end else begin
            ph_r <= ph_r + 2'h1;
            step_tick <= 1'b0;
            if (load)
                pos <= load_pos;
            if (motion_cmd.run) begin
                left_r <= coast;
                dir_r <= motion_cmd.dir;
            end
            if ((motion_cmd.run || left_r != 4'h0) && ph_r == 2'h3) begin
                step_tick <= 1'b1;
                pos <= pos + ((motion_cmd.run ? motion_cmd.dir : dir_r)
                    ? 32'sd1 : -32'sd1);
                if (!motion_cmd.run)
                    left_r <= left_r - 4'h1;
            end
        end
    end
    // Sensors are position windows; coasting ends before at rest
    assign motion_stopped = !motion_cmd.run && left_r == 4'h0;
    assign home_sensor_input = pos >= HOME_LO && pos <= HOME_HI;
    assign forward_limit_input = pos >= LIMIT;
    assign reverse_limit_input = pos <= -LIMIT;
endmodule : motion_stage_model

// *** tb/homing_sequencer_test.sv ***
/*
 Self-checking bench of the homing sequencer.
 Assumes the motion stage model and the bound checker.
*/
`timescale 1ns/1ns
`include "homing_regs.svh"
module homing_sequencer_test;
    import homing_pkg::*;
    typedef struct packed {
        logic [7:0]         meth, mode, dir, zen;
        logic signed [31:0] start, fin;
        logic               fdir;
        logic [31:0]        spd;
    } row_t;
    localparam logic [31:0] V_SW = 32'h0000_0100;
    localparam logic [31:0] V_ZERO = 32'h0000_0080;
    localparam logic [31:0] V_START = 32'h0000_0040;
    localparam logic [31:0] STEPS = 32'h0000_0005;
    // Method, mode, direction, zero enable, start, home, first dir, speed
    row_t rows [11] = '{
        '{8'h18, 8'h0, 8'h0, 8'h0, 0, 20, 1'b1, V_SW},
        '{8'h18, 8'h0, 8'h0, 8'h0, 40, 29, 1'b1, V_SW},
        '{8'h1C, 8'h0, 8'h0, 8'h0, 0, 20, 1'b0, V_SW},
        '{8'h11, 8'h0, 8'h0, 8'h0, 0, -54, 1'b0, V_START},
        '{8'h12, 8'h0, 8'h0, 8'h0, 0, 54, 1'b1, V_START},
        '{8'hFF, 8'h1, 8'h1, 8'h0, 40, 29, 1'b1, V_SW},
        '{8'hFF, 8'h1, 8'h0, 8'h0, 0, 20, 1'b0, V_SW},
        '{8'hFF, 8'h0, 8'h0, 8'h0, 0, -54, 1'b0, V_START},
        '{8'hFF, 8'h0, 8'h1, 8'h0, 0, 54, 1'b1, V_START},
        '{8'hFF, 8'h2, 8'h1, 8'h0, 0, 35, 1'b1, V_SW},
        '{8'hFF, 8'h1, 8'h1, 8'h2, 0, 24, 1'b1, V_SW}};
    logic               clock, rst, obj_wr, obj_rd, home_start;
    logic               op_enabled, load, obj_err, home_set, step_tick;
    logic               home_sensor_input, forward_limit_input;
    logic               reverse_limit_input, encoder_zero_signal;
    logic               motion_stopped;
    logic [15:0]        obj_index;
    logic [7:0]         obj_sub;
    logic [31:0]        obj_wdata, obj_rdata, d;
    logic signed [31:0] pos, load_pos;
    logic [3:0]         coast;
    motion_cmd_t        motion_cmd;
    home_status_t       status;
    int                 fails, n_tests, cyc;
    row_t               r;

    // Zero signal pulses at one place inside the home window
    assign encoder_zero_signal = pos == 24;

    homing_sequencer dut (.*, .sensor_input_a(1'b0));

    motion_stage_model stage (.*);

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // A spare cycle after each write keeps strobes from being rewritten
    task automatic wr(input logic [15:0] i, input logic [7:0] s,
                      input logic [31:0] v);
        obj_index = i;
        obj_sub = s;
        obj_wdata = v;
        obj_wr = 1'b1;
        @(posedge clock);
        #1 obj_wr = 1'b0;
        @(posedge clock);
        #1;
    endtask : wr

    task automatic rd(input logic [15:0] i, input logic [7:0] s);
        obj_index = i;
        obj_sub = s;
        obj_rd = 1'b1;
        @(posedge clock);
        #1 obj_rd = 1'b0;
        d = obj_rdata;
    endtask : rd

    task automatic go(input logic signed [31:0] p);
        load_pos = p;
        load = 1'b1;
        @(posedge clock);
        #1 load = 1'b0;
        home_start = 1'b1;
        @(posedge clock);
        #1 home_start = 1'b0;
    endtask : go

    // Bounded wait for completion or the error flag
    task automatic wait_end;
        for (int i = 0; i < 3000; i++) begin
            @(posedge clock);
            #1;
            if (status.done === 1'b1 || status.error === 1'b1)
                break;
        end
    endtask : wait_end

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Runaway guard; the whole run needs well under this
    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        {rst, load, coast, load_pos} = {1'b1, 1'b0, 4'h0, 32'h0};
        {obj_wr, obj_rd, home_start, op_enabled} = 4'h0;
        {obj_index, obj_sub, obj_wdata} = '0;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        rd(`IDX_METHOD, 8'h00);
        check(d, {24'h0, `RST_METHOD});
        rd(`IDX_START_DIR, 8'h00);
        check(d, {24'h0, `RST_START_DIR});
        rd(16'h4170, 8'h00);
        check({d[30:0], obj_err}, 32'h0000_0001);
        wr(`IDX_SPEEDS, `SUB_SW_SPEED, V_SW);
        wr(`IDX_SPEEDS, `SUB_ZERO_SPEED, V_ZERO);
        wr(`IDX_START_SPEED, 8'h00, V_START);
        wr(`IDX_BACK_STEPS, 8'h00, STEPS);
        wr(`IDX_ONE_WAY, 8'h00, STEPS);
        rd(`IDX_BACK_STEPS, 8'h00);
        check(d, STEPS);
        $display("registers done");
        op_enabled = 1'b1;
        foreach (rows[k]) begin
            r = rows[k];
            wr(`IDX_METHOD, 8'h00, {24'h0, r.meth});
            wr(`IDX_MODE, 8'h00, {24'h0, r.mode});
            wr(`IDX_START_DIR, 8'h00, {24'h0, r.dir});
            wr(`IDX_ZERO_EN, 8'h00, {24'h0, r.zen});
            go(r.start);
            check({motion_cmd.run, motion_cmd.dir}, {1'b1, r.fdir});
            check(motion_cmd.speed, r.spd);
            wait_end();
            check({status.done, home_set}, 2'h3);
            check(pos, r.fin);
            $display("row %0d done", k);
        end
        op_enabled = 1'b0;
        for (int m = 0; m < 2; m++) begin
            wr(`IDX_METHOD, 8'h00, m ? 32'h25 : 32'h23);
            go(-7);
            check({home_set, status.done, motion_cmd.run}, 3'h6);
        end
        op_enabled = 1'b1;
        go(3);
        check({home_set, status.busy}, 2'h0);
        $display("preset done");
        coast = 4'hC;
        wr(`IDX_METHOD, 8'h00, 32'hFF);
        wr(`IDX_MODE, 8'h00, 32'h02);
        wr(`IDX_ZERO_EN, 8'h00, 32'h00);
        go(0);
        wait_end();
        check({status.error, status.done}, 2'h2);
        check(status.alarm_code, 32'h62);
        $display("alarm done");
        report_and_stop();
    end
endmodule : homing_sequencer_test
